// >>> logic/ccr_pkg.sv
/*
  Constants shared by the charger configuration register bank and its
  host watchdog: register offsets, field positions, reset values, encoding
  steps and timer figures.
  Assumes a 100 MHz system clock.
*/
package ccr_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_S = 1_000_000_000;
	localparam int SEC_CYCLES_DFLT = NS_PER_S / CLK_PERIOD_NS;

	// register offsets
	localparam logic [7:0] OFS_KICK = 8'h01;
	localparam logic [7:0] OFS_CURRENT = 8'h03;
	localparam logic [7:0] OFS_VOLTAGE = 8'h04;
	localparam logic [7:0] OFS_TIMER_CTL = 8'h05;
	localparam logic [7:0] OFS_INPUT = 8'h06;

	// field positions
	localparam int KICK_BIT = 6;
	localparam int PRECHG_LSB = 4;
	localparam int TERM_LSB = 0;
	localparam int CHARGE_VOLTAGE_SEL_LSB = 3;
	localparam int TOPOFF_LSB = 1;
	localparam int RECHG_BIT = 0;
	localparam int TERM_EN_BIT = 7;
	localparam int WDOG_LSB = 4;
	localparam int SAFETY_EN_BIT = 3;
	localparam int SAFETY_SEL_BIT = 2;
	localparam int THERMAL_BIT = 1;
	localparam int COLD_BIT = 0;
	localparam int OVP_LSB = 6;
	localparam int BOOST_LSB = 4;
	localparam int FLOOR_LSB = 0;

	// values after reset
	localparam logic [7:0] RST_CURRENT = 8'h22;
	localparam logic [7:0] RST_VOLTAGE = 8'h58;
	localparam logic [7:0] RST_TIMER_CTL = 8'h9f;
	localparam logic [7:0] RST_INPUT = 8'h66;

	// encodings
	localparam logic [3:0] PRECHG_MAX_CODE = 4'hc;
	localparam logic [4:0] CHARGE_VOLTAGE_SEL_MAX_CODE = 5'h18;
	localparam logic [4:0] CHARGE_VOLTAGE_SEL_SPECIAL_CODE = 5'h0f;
	localparam logic [12:0] CHARGE_VOLTAGE_SEL_SPECIAL_MV = 13'h1100;
	localparam logic [12:0] CHARGE_VOLTAGE_SEL_OFFSET_MV = 13'h0f10;
	localparam logic [12:0] CHARGE_VOLTAGE_SEL_STEP_MV = 13'h0020;
	localparam logic [9:0] CUR_OFFSET_MA = 10'h03c;
	localparam logic [9:0] CUR_STEP_MA = 10'h03c;
	localparam logic [12:0] FLOOR_OFFSET_MV = 13'h0f3c;
	localparam logic [12:0] FLOOR_STEP_MV = 13'h0064;

	// watchdog periods in seconds
	localparam logic [1:0] WDOG_OFF = 2'h0;
	localparam logic [7:0] WDOG_S_01 = 8'd40;
	localparam logic [7:0] WDOG_S_10 = 8'd80;
	localparam logic [7:0] WDOG_S_11 = 8'd160;

endpackage

// >>> logic/ccr_wdog_if.sv
/*
  Interface between the register bank and the host watchdog timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface ccr_wdog_if;
	logic [1:0] period_sel;
	logic kick;
	logic kick_ack;
	logic expire;

	modport timer (input period_sel, input kick, output kick_ack, output expire);
	modport bank (output period_sel, output kick, input kick_ack, input expire);
endinterface

// >>> logic/ccr_host_watchdog.sv
/*
  Host watchdog timer: a one-second prescaler and a seconds counter.
  Assumes kick is a level from the register bank held until kick_ack.
*/
`timescale 1ns/1ps
module ccr_host_watchdog #(
	parameter int SEC_CYCLES = ccr_pkg::SEC_CYCLES_DFLT
) (
	input wire logic CLK,
	input wire logic RESET,
	ccr_wdog_if.timer wd
);
	import ccr_pkg::*;

	initial
	begin
		if (SEC_CYCLES < 2)
			$error("SEC_CYCLES must be at least 2");
	end

	logic [31:0] pre_cnt;
	logic [7:0] sec_cnt;
	logic [7:0] limit;
	logic sec_tick;
	logic restart;

	always_comb
	begin
		case (wd.period_sel)
			2'h1: limit = WDOG_S_01;
			2'h2: limit = WDOG_S_10;
			2'h3: limit = WDOG_S_11;
			default: limit = 8'h00;
		endcase
	end

	assign sec_tick = (pre_cnt == 32'(SEC_CYCLES - 1));
	// disabled timer stays cleared and never fires
	assign restart = wd.kick || (wd.period_sel == WDOG_OFF);

	always_ff @(posedge CLK)
	begin
		if (RESET || restart || sec_tick)
			pre_cnt <= 32'h0;
		else
			pre_cnt <= pre_cnt + 32'h1;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET || restart || wd.expire)
			sec_cnt <= 8'h00;
		else if (sec_tick)
			sec_cnt <= sec_cnt + 8'h01;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			wd.expire <= 1'b0;
		else
			wd.expire <= !restart && !wd.expire && (sec_cnt == limit) && (limit != 8'h00);
	end

	// acknowledge the kick once the counters have been cleared
	always_ff @(posedge CLK)
	begin
		if (RESET)
			wd.kick_ack <= 1'b0;
		else
			wd.kick_ack <= wd.kick;
	end

endmodule

// >>> logic/ccr_config_bank.sv
/*
  Charger configuration register bank behind an I2C target port: four
  byte registers of charge settings, the watchdog kick bit and the host
  watchdog that restores the first three registers to defaults on expiry.
  Assumes SCL and SDA arrive asynchronously and are resolved as open-drain
  wires outside; a register-reset command arrives as a one-cycle pulse
  from logic on CLK.
*/
// Operation
// - precharge code: 60 mA offset plus 60 mA per step, default 0010.
// - precharge codes above 1100 are stored as 1100.
// - termination code: 60 mA offset plus 60 mA per step, default 0010.
// - charge voltage code: 3.856 V plus 32 mV per step, default 01011.
// - charge voltage codes above 11000 are stored as 11000.
// - charge voltage code 01111 means 4.352 V.
// - two-bit top-off time after termination: none, 15, 30, 45 minutes.
// - recharge offset bit: 0 is 100 mV, 1 is 200 mV, default 0.
// - termination allowed only while enable bit is 1, default 1.
// - watchdog period: off, 40 s, 80 s, 160 s, default 01.
// - one bit enables both safety timers, default 1.
// - fast-charge safety time bit: 5 h or 10 h, default 1.
// - thermal limit bit: 90 C or 110 C, default 1.
// - cold-zone current scale bit: 50 or 20 percent, default 1.
// - input overvoltage select: 5.5, 6.5, 10.5, 14 V, default 01.
// - boost voltage select: 4.85, 5.00, 5.15, 5.30 V, default 10.
// - input voltage floor: 3.9 V plus 100 mV per step, default 0110.
// - reset command restores all four; watchdog expiry restores first three.
// - host writes 1 to kick; device clears it after timer reset.
`timescale 1ns/1ps
module ccr_config_bank #(
	parameter logic [6:0] DEV_ADDR = 7'h50,
	parameter int SEC_CYCLES = ccr_pkg::SEC_CYCLES_DFLT
) (
	input wire logic CLK, // system clock
	input wire logic RESET, // synchronous reset
	input wire logic SCL, // i2c clock pin
	input wire logic SDA_IN, // i2c data pin level
	output logic SDA_OUT, // i2c data drive value
	output logic SDA_OE, // i2c data drive enable
	input wire logic REGS_DEFAULT, // register-reset command pulse
	output logic WDOG_EXPIRED, // watchdog expiry pulse
	output logic [3:0] PRECHG_SEL, // precharge current code
	output logic [3:0] TERM_SEL, // termination current code
	output logic [4:0] CHARGE_VOLTAGE_SEL_SEL, // charge voltage code
	output logic [1:0] TOPOFF_SEL, // top-off time code
	output logic RECHG_SEL, // recharge offset select
	output logic TERM_EN, // termination enable
	output logic [1:0] WDOG_SEL, // watchdog period code
	output logic SAFETY_EN, // safety timers enable
	output logic SAFETY_SEL, // fast-charge safety time select
	output logic THERMAL_SEL, // thermal limit select
	output logic COLD_SCALE, // cold-zone current scale
	output logic [1:0] OVP_SEL, // input overvoltage select
	output logic [1:0] BOOST_SEL, // boost voltage select
	output logic [3:0] FLOOR_SEL, // input voltage floor code
	output logic [9:0] PRECHG_MA, // precharge current in mA
	output logic [9:0] TERM_MA, // termination current in mA
	output logic [12:0] CHARGE_MV, // charge voltage in mV
	output logic [12:0] FLOOR_MV, // input voltage floor in mV
	output logic [5:0] TOPOFF_MIN // top-off time in minutes
);
	import ccr_pkg::*;

	initial
	begin
		if (SEC_CYCLES < 2)
			$error("SEC_CYCLES must be at least 2");
	end

	typedef enum {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} ccr_state_t;

	function automatic logic [9:0] ccr_current_ma(input logic [3:0] code);
		ccr_current_ma = CUR_OFFSET_MA + 10'(CUR_STEP_MA * 10'(code));
	endfunction

	// storing clamp for precharge code
	function automatic logic [3:0] ccr_clamp_prechg(input logic [3:0] code);
		ccr_clamp_prechg = (code > PRECHG_MAX_CODE) ? PRECHG_MAX_CODE : code;
	endfunction

	function automatic logic [4:0] ccr_clamp_charge_voltage_sel(input logic [4:0] code);
		ccr_clamp_charge_voltage_sel = (code > CHARGE_VOLTAGE_SEL_MAX_CODE) ? CHARGE_VOLTAGE_SEL_MAX_CODE : code;
	endfunction

	logic [7:0] reg_current;
	logic [7:0] reg_voltage;
	logic [7:0] reg_timer_ctl;
	logic [7:0] reg_input;
	logic kick;

	ccr_wdog_if wd_if ();

	ccr_host_watchdog #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_wdog (
		.CLK(CLK),
		.RESET(RESET),
		.wd(wd_if.timer)
	);

	assign wd_if.period_sel = reg_timer_ctl[WDOG_LSB +: 2];
	assign wd_if.kick = kick;

	// pin synchronisers and edge detection
	logic scl_s1;
	logic scl_s2;
	logic scl_d;
	logic sda_s1;
	logic sda_s2;
	logic sda_d;

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_s1 <= SCL;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= SDA_IN;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise = scl_s2 && !scl_d;
	assign scl_fall = !scl_s2 && scl_d;
	assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
	assign bus_stop = scl_s2 && scl_d && !sda_d && sda_s2;

	// read view of the register map; unmapped offsets read zero
	function automatic logic [7:0] ccr_read(input logic [7:0] ofs);
		case (ofs)
			OFS_KICK: ccr_read = 8'(kick) << KICK_BIT;
			OFS_CURRENT: ccr_read = reg_current;
			OFS_VOLTAGE: ccr_read = reg_voltage;
			OFS_TIMER_CTL: ccr_read = reg_timer_ctl;
			OFS_INPUT: ccr_read = reg_input;
			default: ccr_read = 8'h00;
		endcase
	endfunction

	// i2c target state machine
	ccr_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic [7:0] ptr;
	logic master_nack;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_byte;

	// byte at the pointer, so its top bit can be driven as the first data bit
	always_comb
	begin
		rd_byte = ccr_read(ptr);
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			txreg <= 8'h00;
			ptr <= 8'h00;
			master_nack <= 1'b0;
			SDA_OE <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end
		else
		begin
			wr_stb <= 1'b0;
			if (bus_start)
			begin
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				SDA_OE <= 1'b0;
			end
			else if (bus_stop)
			begin
				state <= ST_IDLE;
				SDA_OE <= 1'b0;
			end
			else
			begin
				case (state)
					ST_ADDR, ST_PTR, ST_WDATA:
					begin
						if (scl_rise)
						begin
							shreg <= {shreg[6:0], sda_s2};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == 4'h8)
						begin
							bit_cnt <= 4'h0;
							if (state == ST_ADDR)
							begin
								if (shreg[7:1] == DEV_ADDR)
								begin
									master_nack <= shreg[0];
									SDA_OE <= 1'b1;
									state <= ST_ADDR_ACK;
								end
								else
									state <= ST_IDLE;
							end
							else if (state == ST_PTR)
							begin
								ptr <= shreg;
								SDA_OE <= 1'b1;
								state <= ST_PTR_ACK;
							end
							else
							begin
								wr_stb <= 1'b1;
								wr_addr <= ptr;
								wr_data <= shreg;
								ptr <= ptr + 8'h01;
								SDA_OE <= 1'b1;
								state <= ST_WDATA_ACK;
							end
						end
					end
					ST_ADDR_ACK:
					begin
						if (scl_fall)
						begin
							// the latched direction bit selects read or write
							if (master_nack)
							begin
								txreg <= rd_byte;
								SDA_OE <= !rd_byte[7];
								state <= ST_RDATA;
							end
							else
							begin
								SDA_OE <= 1'b0;
								state <= ST_PTR;
							end
						end
					end
					ST_PTR_ACK, ST_WDATA_ACK:
					begin
						if (scl_fall)
						begin
							SDA_OE <= 1'b0;
							state <= ST_WDATA;
						end
					end
					ST_RDATA:
					begin
						if (scl_rise)
							bit_cnt <= bit_cnt + 4'h1;
						else if (scl_fall)
						begin
							if (bit_cnt == 4'h8)
							begin
								bit_cnt <= 4'h0;
								SDA_OE <= 1'b0;
								ptr <= ptr + 8'h01;
								state <= ST_RACK;
							end
							else
							begin
								txreg <= {txreg[6:0], 1'b0};
								SDA_OE <= !txreg[6];
							end
						end
					end
					ST_RACK:
					begin
						if (scl_rise)
							master_nack <= sda_s2;
						else if (scl_fall)
						begin
							if (master_nack)
								state <= ST_IDLE;
							else
							begin
								txreg <= rd_byte;
								SDA_OE <= !rd_byte[7];
								state <= ST_RDATA;
							end
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge CLK)
	begin
		SDA_OUT <= 1'b0;
	end

	// registers restored by both reset sources
	always_ff @(posedge CLK)
	begin
		if (RESET || REGS_DEFAULT || wd_if.expire)
		begin
			reg_current <= RST_CURRENT;
			reg_voltage <= RST_VOLTAGE;
			reg_timer_ctl <= RST_TIMER_CTL;
		end
		else if (wr_stb)
		begin
			case (wr_addr)
				OFS_CURRENT:
					reg_current <= {ccr_clamp_prechg(wr_data[PRECHG_LSB +: 4]),
						wr_data[TERM_LSB +: 4]};
				OFS_VOLTAGE:
					reg_voltage <= {ccr_clamp_charge_voltage_sel(wr_data[CHARGE_VOLTAGE_SEL_LSB +: 5]),
						wr_data[2:0]};
				OFS_TIMER_CTL:
					reg_timer_ctl <= wr_data;
				default:
				begin
					reg_current <= reg_current;
				end
			endcase
		end
	end

	// register restored only by the register-reset command
	always_ff @(posedge CLK)
	begin
		if (RESET || REGS_DEFAULT)
			reg_input <= RST_INPUT;
		else if (wr_stb && wr_addr == OFS_INPUT)
			reg_input <= wr_data;
	end

	// kick bit: a fresh write of 1 wins over the acknowledge
	always_ff @(posedge CLK)
	begin
		if (RESET || REGS_DEFAULT)
			kick <= 1'b0;
		else if (wr_stb && wr_addr == OFS_KICK && wr_data[KICK_BIT])
			kick <= 1'b1;
		else if (wd_if.kick_ack || wd_if.expire)
			kick <= 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			WDOG_EXPIRED <= 1'b0;
		else
			WDOG_EXPIRED <= wd_if.expire;
	end

	// field outputs and decoded physical values
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			PRECHG_SEL <= RST_CURRENT[PRECHG_LSB +: 4];
			TERM_SEL <= RST_CURRENT[TERM_LSB +: 4];
			CHARGE_VOLTAGE_SEL_SEL <= RST_VOLTAGE[CHARGE_VOLTAGE_SEL_LSB +: 5];
			TOPOFF_SEL <= RST_VOLTAGE[TOPOFF_LSB +: 2];
			RECHG_SEL <= RST_VOLTAGE[RECHG_BIT];
			TERM_EN <= RST_TIMER_CTL[TERM_EN_BIT];
			WDOG_SEL <= RST_TIMER_CTL[WDOG_LSB +: 2];
			SAFETY_EN <= RST_TIMER_CTL[SAFETY_EN_BIT];
			SAFETY_SEL <= RST_TIMER_CTL[SAFETY_SEL_BIT];
			THERMAL_SEL <= RST_TIMER_CTL[THERMAL_BIT];
			COLD_SCALE <= RST_TIMER_CTL[COLD_BIT];
			OVP_SEL <= RST_INPUT[OVP_LSB +: 2];
			BOOST_SEL <= RST_INPUT[BOOST_LSB +: 2];
			FLOOR_SEL <= RST_INPUT[FLOOR_LSB +: 4];
		end
		else
		begin
			PRECHG_SEL <= reg_current[PRECHG_LSB +: 4];
			TERM_SEL <= reg_current[TERM_LSB +: 4];
			CHARGE_VOLTAGE_SEL_SEL <= reg_voltage[CHARGE_VOLTAGE_SEL_LSB +: 5];
			TOPOFF_SEL <= reg_voltage[TOPOFF_LSB +: 2];
			RECHG_SEL <= reg_voltage[RECHG_BIT];
			TERM_EN <= reg_timer_ctl[TERM_EN_BIT];
			WDOG_SEL <= reg_timer_ctl[WDOG_LSB +: 2];
			SAFETY_EN <= reg_timer_ctl[SAFETY_EN_BIT];
			SAFETY_SEL <= reg_timer_ctl[SAFETY_SEL_BIT];
			THERMAL_SEL <= reg_timer_ctl[THERMAL_BIT];
			COLD_SCALE <= reg_timer_ctl[COLD_BIT];
			OVP_SEL <= reg_input[OVP_LSB +: 2];
			BOOST_SEL <= reg_input[BOOST_LSB +: 2];
			FLOOR_SEL <= reg_input[FLOOR_LSB +: 4];
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			PRECHG_MA <= 10'h000;
			TERM_MA <= 10'h000;
			CHARGE_MV <= 13'h0000;
			FLOOR_MV <= 13'h0000;
			TOPOFF_MIN <= 6'h00;
		end
		else
		begin
			PRECHG_MA <= ccr_current_ma(reg_current[PRECHG_LSB +: 4]);
			TERM_MA <= ccr_current_ma(reg_current[TERM_LSB +: 4]);
			if (reg_voltage[CHARGE_VOLTAGE_SEL_LSB +: 5] == CHARGE_VOLTAGE_SEL_SPECIAL_CODE)
				CHARGE_MV <= CHARGE_VOLTAGE_SEL_SPECIAL_MV;
			else
				CHARGE_MV <= CHARGE_VOLTAGE_SEL_OFFSET_MV
					+ 13'(CHARGE_VOLTAGE_SEL_STEP_MV * 13'(reg_voltage[CHARGE_VOLTAGE_SEL_LSB +: 5]));
			FLOOR_MV <= FLOOR_OFFSET_MV
				+ 13'(FLOOR_STEP_MV * 13'(reg_input[FLOOR_LSB +: 4]));
			// 15 minutes per step, zero ends charge at termination
			TOPOFF_MIN <= 6'(6'd15 * 6'(reg_voltage[TOPOFF_LSB +: 2]));
		end
	end

endmodule

// >>> tb/ccr_config_bank_assertions.sv
/* checker on the bank's field and decoded outputs
   assumes it is bound to ccr_config_bank on one clock */
`timescale 1ns/1ps
module ccr_config_bank_assertions (
	input wire logic CLK, // clock
	input wire logic RESET, // sync reset
	input wire logic REGS_DEFAULT, // reset command
	input wire logic WDOG_EXPIRED, // expiry pulse
	input wire logic [3:0] PRECHG_SEL, // precharge code
	input wire logic [3:0] TERM_SEL, // term code
	input wire logic [4:0] CHARGE_VOLTAGE_SEL_SEL, // voltage code
	input wire logic [1:0] TOPOFF_SEL, // top-off code
	input wire logic [1:0] WDOG_SEL, // period code
	input wire logic [1:0] OVP_SEL, // ovp code
	input wire logic [1:0] BOOST_SEL, // boost code
	input wire logic [3:0] FLOOR_SEL, // floor code
	input wire logic [9:0] PRECHG_MA, // precharge mA
	input wire logic [9:0] TERM_MA, // term mA
	input wire logic [12:0] CHARGE_MV, // charge mV
	input wire logic [12:0] FLOOR_MV, // floor mV
	input wire logic [5:0] TOPOFF_MIN // top-off minutes
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// fields of the first three registers, and of the fourth, at defaults
	wire d3 = {PRECHG_SEL, TERM_SEL} == 8'h22 && {CHARGE_VOLTAGE_SEL_SEL, TOPOFF_SEL} == 7'h2c && WDOG_SEL == 2'h1;
	wire d6 = {OVP_SEL, BOOST_SEL, FLOOR_SEL} == 8'h66;
	a_prechg_clamp: assert property (PRECHG_SEL <= 4'hc)
		else $error("precharge code above clamp");
	a_charge_voltage_sel_clamp: assert property (CHARGE_VOLTAGE_SEL_SEL <= 5'h18)
		else $error("voltage code above clamp");
	a_prechg_decode: assert property (!$past(RESET) |-> PRECHG_MA == 10'd60 + 10'd60 * PRECHG_SEL)
		else $error("precharge mA wrong");
	a_term_decode: assert property (!$past(RESET) |-> TERM_MA == 10'd60 + 10'd60 * TERM_SEL)
		else $error("term mA wrong");
	a_charge_voltage_sel_decode: assert property (!$past(RESET) |->
		CHARGE_MV == (CHARGE_VOLTAGE_SEL_SEL == 5'h0f ? 13'd4352 : 13'd3856 + 13'd32 * CHARGE_VOLTAGE_SEL_SEL))
		else $error("charge mV wrong");
	a_floor_decode: assert property (!$past(RESET) |-> FLOOR_MV == 13'd3900 + 13'd100 * FLOOR_SEL)
		else $error("floor mV wrong");
	a_topoff_decode: assert property (!$past(RESET) |-> TOPOFF_MIN == 6'd15 * TOPOFF_SEL)
		else $error("top-off minutes wrong");
	a_cmd_restore: assert property (REGS_DEFAULT |-> ##[1:2] (d3 && d6))
		else $error("reset command did not restore");
	a_expiry_restore: assert property (WDOG_EXPIRED |-> ##[0:2] d3)
		else $error("expiry did not restore");
	a_wdog_off: assert property (WDOG_SEL == 2'h0 && $past(WDOG_SEL) == 2'h0 |=> !WDOG_EXPIRED)
		else $error("expiry while timer off");
	c_cmd: cover property (REGS_DEFAULT);
	c_expiry: cover property (WDOG_EXPIRED);
	c_special: cover property (CHARGE_VOLTAGE_SEL_SEL == 5'h0f);
endmodule
bind ccr_config_bank ccr_config_bank_assertions u_chk (.CLK(CLK), .RESET(RESET),
	.REGS_DEFAULT(REGS_DEFAULT), .WDOG_EXPIRED(WDOG_EXPIRED), .PRECHG_SEL(PRECHG_SEL),
	.TERM_SEL(TERM_SEL), .CHARGE_VOLTAGE_SEL_SEL(CHARGE_VOLTAGE_SEL_SEL), .TOPOFF_SEL(TOPOFF_SEL), .WDOG_SEL(WDOG_SEL),
	.OVP_SEL(OVP_SEL), .BOOST_SEL(BOOST_SEL), .FLOOR_SEL(FLOOR_SEL), .PRECHG_MA(PRECHG_MA),
	.TERM_MA(TERM_MA), .CHARGE_MV(CHARGE_MV), .FLOOR_MV(FLOOR_MV), .TOPOFF_MIN(TOPOFF_MIN));

// >>> tb/ccr_i2c_host.sv
/* i2c host model: register writes and pointer reads
   assumes sda is resolved outside as a pulled-up open-drain wire */
`timescale 1ns/1ps
module ccr_i2c_host (
	input wire logic clk, // system clock
	input wire logic sda, // resolved data line
	output logic scl, // clock pin
	output logic sda_low, // pulls data low
	output logic res_valid, // read byte strobe
	output logic [7:0] res_data // read byte
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_valid = 1'b0;
		res_data = 8'h00;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// scl low and high phases of 8 cycles; data moves mid-low
	task automatic bit_io(input logic b, output logic s);
		wt(4);
		sda_low <= !b;
		wt(4);
		scl <= 1'b1;
		wt(4);
		s = sda;
		wt(4);
		scl <= 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] q);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(b9, s);
	endtask
	// serves as start and repeated start
	task automatic start();
		wt(4);
		sda_low <= 1'b0;
		wt(4);
		scl <= 1'b1;
		wt(8);
		sda_low <= 1'b1;
		wt(8);
		scl <= 1'b0;
	endtask
	task automatic stop();
		wt(4);
		sda_low <= 1'b1;
		wt(4);
		scl <= 1'b1;
		wt(8);
		sda_low <= 1'b0;
		wt(8);
	endtask
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		start();
		byte_io({dev, 1'b0}, 1'b1, q);
		byte_io(p, 1'b1, q);
		byte_io(d, 1'b1, q);
		stop();
	endtask
	// acks every byte but the last
	task automatic read_regs(input logic [6:0] dev, input logic [7:0] p, input int n);
		logic [7:0] q;
		start();
		byte_io({dev, 1'b0}, 1'b1, q);
		byte_io(p, 1'b1, q);
		start();
		byte_io({dev, 1'b1}, 1'b1, q);
		for (int i = 0; i < n; i++)
		begin
			byte_io(8'hff, i == n - 1, q);
			res_data <= q;
			res_valid <= 1'b1;
			wt(1);
			res_valid <= 1'b0;
		end
		stop();
	endtask
endmodule

// >>> tb/ccr_config_bank_tb.sv
/* self-checking bench for the charger configuration bank
   assumes the i2c host model as the only register master */
`timescale 1ns/1ps
module ccr_config_bank_tb;
	localparam logic [6:0] ADDR = 7'h50;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic regs_default = 1'b0;
	logic scl, sda_out, sda_oe, host_low, rd_valid, wdog_expired, rechg_sel, term_en;
	logic safety_en, safety_sel, thermal_sel, cold_scale;
	logic [1:0] topoff_sel, wdog_sel, ovp_sel, boost_sel;
	logic [3:0] prechg_sel, term_sel, floor_sel;
	logic [4:0] charge_voltage_sel_sel;
	logic [7:0] rd_data, r;
	logic [9:0] prechg_ma, term_ma;
	logic [12:0] charge_mv, floor_mv;
	logic [5:0] topoff_min;
	logic [7:0] shadow [3:6];
	logic [7:0] exp_q [$];
	logic [4:0] vt [4] = '{5'h19, 5'h0f, 5'h18, 5'h1f};
	int error_cnt = 0;
	int tests_run = 0;
	int seed = 32'h97d0ee5a;
	int n;
	wire sda = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
	always #5 clk = ~clk;
	ccr_config_bank #(.DEV_ADDR(ADDR), .SEC_CYCLES(400)) u_ccr_config_bank (.CLK(clk),
		.RESET(reset), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.REGS_DEFAULT(regs_default), .WDOG_EXPIRED(wdog_expired), .PRECHG_SEL(prechg_sel),
		.TERM_SEL(term_sel), .CHARGE_VOLTAGE_SEL_SEL(charge_voltage_sel_sel), .TOPOFF_SEL(topoff_sel), .RECHG_SEL(rechg_sel),
		.TERM_EN(term_en), .WDOG_SEL(wdog_sel), .SAFETY_EN(safety_en), .SAFETY_SEL(safety_sel),
		.THERMAL_SEL(thermal_sel), .COLD_SCALE(cold_scale), .OVP_SEL(ovp_sel),
		.BOOST_SEL(boost_sel), .FLOOR_SEL(floor_sel), .PRECHG_MA(prechg_ma), .TERM_MA(term_ma),
		.CHARGE_MV(charge_mv), .FLOOR_MV(floor_mv), .TOPOFF_MIN(topoff_min));
	ccr_i2c_host u_ccr_i2c_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low),
		.res_valid(rd_valid), .res_data(rd_data));
	task automatic complete_run();
		$display("errors %0d compares %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch read byte exp %h got %h", e, g);
		end
	endtask
	task automatic cmp_val(input string s, input logic [12:0] g, input logic [12:0] e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %0d got %0d", s, e, g);
		end
	endtask
	always @(posedge clk)
		if (rd_valid === 1'b1)
			cmp_byte(exp_q.size() ? exp_q.pop_front() : 8'hxx, rd_data);
	task automatic defaults(input logic all);
		shadow[3] = 8'h22;
		shadow[4] = 8'h58;
		shadow[5] = 8'h9f;
		if (all) shadow[6] = 8'h66;
	endtask
	task automatic check_fields();
		logic [7:0] v;
		v = shadow[4];
		cmp_val("current", {prechg_sel, term_sel}, shadow[3]);
		cmp_val("voltage", {charge_voltage_sel_sel, topoff_sel, rechg_sel}, v);
		cmp_val("control", {term_en, 1'b0, wdog_sel, safety_en, safety_sel, thermal_sel,
			cold_scale}, shadow[5] & 8'hbf);
		cmp_val("input", {ovp_sel, boost_sel, floor_sel}, shadow[6]);
		cmp_val("prechg_ma", prechg_ma, 13'd60 + 13'd60 * shadow[3][7:4]);
		cmp_val("term_ma", term_ma, 13'd60 + 13'd60 * shadow[3][3:0]);
		cmp_val("charge_mv", charge_mv, (v[7:3] == 5'h0f) ? 13'd4352 :
			13'd3856 + 13'd32 * v[7:3]);
		cmp_val("floor_mv", floor_mv, 13'd3900 + 13'd100 * shadow[6][3:0]);
		cmp_val("topoff_min", topoff_min, 13'd15 * v[2:1]);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		u_ccr_i2c_host.write_reg(ADDR, p, d);
		if (p == 8'h03 && d[7:4] > 4'hc) d[7:4] = 4'hc;
		if (p == 8'h04 && d[7:3] > 5'h18) d[7:3] = 5'h18;
		shadow[p[2:0]] = d;
	endtask
	task automatic rd(input logic [7:0] p, input int k);
		for (int i = 0; i < k; i++)
			exp_q.push_back(shadow[p + i]);
		u_ccr_i2c_host.read_regs(ADDR, p, k);
	endtask
	initial
	begin
		defaults(1'b1);
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		check_fields();
		rd(8'h03, 4);
		// every code of the two-bit fields, clamp boundaries and the special code
		for (int i = 0; i < 4; i++)
		begin
			r = 8'($random(seed));
			wr(8'h03, (i == 0) ? 8'hd5 : r);
			wr(8'h04, {vt[i], 2'(i), 1'(i)});
			wr(8'h05, {r[7:6], 2'(i), r[3:0]});
			wr(8'h06, {2'(i), 2'(i), r[7:4]});
			check_fields();
			rd(8'h03, 4);
		end
		wr(8'h05, 8'h8f);
		repeat (17000) @(posedge clk);
		rd(8'h03, 4);
		u_ccr_i2c_host.write_reg(ADDR, 8'h02, 8'h5a);
		exp_q.push_back(8'h00);
		u_ccr_i2c_host.read_regs(ADDR, 8'h07, 1);
		exp_q.push_back(8'hff);
		u_ccr_i2c_host.read_regs(7'h51, 8'h03, 1);
		wr(8'h06, 8'hd3);
		@(posedge clk);
		regs_default <= 1'b1;
		@(posedge clk);
		regs_default <= 1'b0;
		repeat (3) @(posedge clk);
		defaults(1'b1);
		check_fields();
		rd(8'h03, 4);
		wr(8'h06, 8'hd3);
		wr(8'h03, 8'h4a);
		u_ccr_i2c_host.write_reg(ADDR, 8'h01, 8'h40);
		exp_q.push_back(8'h00);
		u_ccr_i2c_host.read_regs(ADDR, 8'h01, 1);
		n = 0;
		while (wdog_expired !== 1'b1 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 20000)
			error_cnt++;
		else
		begin
			repeat (3) @(posedge clk);
			defaults(1'b0);
			check_fields();
			rd(8'h03, 4);
		end
		repeat (4) @(posedge clk);
		error_cnt += exp_q.size();
		complete_run();
	end
endmodule
